// ===== mdp_pkg.sv
// Constants, types and register map of the dithered multichannel PWM block
//------------------------------------------------------------------------------
// What this block does
// - A configured channel stays configured and running; only power-up reset clears it.
// - Init call configures a channel once; raw mode latches period then.
// - Output frequency is clamped so it never exceeds 5 kHz.
// - Prescale select off runs counter at clock; on divides clock by 64.
// - New duty is adopted only with the commit strobe set.
// - Raw dither frequency equals output frequency over twice the divider.
// - Dither divider and amplitude are assigned in the init call.
// - Each channel holds its own dither rate and amplitude.
// - Frequency modes take hertz and derive the counter period internally.
// - Percent mode reads duty as 8 bits at 1 % steps.
// - Permille mode reads duty at one thousandth steps of the period.
// - Frequency modes take dither rate in hertz, amplitude in percent, at init.
// - Output sets when counter reaches compare, clears on wrap.
// - A preload shortens the counter range and raises the frequency.
// - Dither alternately raises and lowers duty by the amplitude.
// - Each independent channel keeps its own period preload.
//------------------------------------------------------------------------------
package mdp_pkg;
  // Clock and frequency limits
  localparam int CLK_HZ = 50_000_000;
  localparam int MAX_PWM_HZ = 5_000;
  localparam int PRESCALE_DIV = 64;
  localparam logic [15:0] MAX_PWM_HZ_W = 16'(MAX_PWM_HZ);
  // Least period in counts: 5 kHz rounded up to whole counts
  localparam logic [15:0] MIN_PERIOD_FULL =
    16'((CLK_HZ + MAX_PWM_HZ - 1) / MAX_PWM_HZ);
  localparam logic [15:0] MIN_PERIOD_SLOW =
    16'((CLK_HZ + PRESCALE_DIV * MAX_PWM_HZ - 1) / (PRESCALE_DIV * MAX_PWM_HZ));
  localparam logic [31:0] BASE_FULL_HZ = 32'(CLK_HZ);
  localparam logic [31:0] BASE_SLOW_HZ = 32'(CLK_HZ / PRESCALE_DIV);
  localparam logic [5:0] PRESCALE_LAST = 6'(PRESCALE_DIV - 1);
  localparam logic [5:0] DIV_STEPS = 6'h20;
  // Channel layout
  localparam int NUM_CH = 8;
  localparam int NUM_TB = 5;
  localparam int GROUP_BASE = 4;
  // Scales and reset values
  localparam logic [15:0] PERCENT_SCALE = 16'h0064;
  localparam logic [15:0] PERMILLE_SCALE = 16'h03E8;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  // Register byte offsets
  localparam logic [7:0] ADDR_PERIOD = 8'h00;
  localparam logic [7:0] ADDR_DUTY = 8'h04;
  localparam logic [7:0] ADDR_DITH_AMP = 8'h08;
  localparam logic [7:0] ADDR_DITH_RATE = 8'h0C;
  localparam logic [7:0] ADDR_CMD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  typedef enum logic [1:0] {
    raw_duty_mode = 2'h0,
    percent_duty_mode = 2'h1,
    permille_duty_mode = 2'h2
  } mdp_mode_type;

  // Command word, low byte of the command register
  typedef struct packed {
    logic slow_prescale_select;
    mdp_mode_type mode;
    logic commit;
    logic init;
    logic [2:0] chan;
  } mdp_cmd_type;

  typedef struct packed {
    mdp_mode_type mode;
    logic slow_prescale_select;
    logic [15:0] period;
    logic [15:0] dith_amp;
    logic [15:0] dith_rate;
  } mdp_cfg_type;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_period = 3'b010,
    st_dither = 3'b100
  } mdp_state_type;
endpackage

// ===== mdp_pwm.sv
// Eight-channel dithered PWM generator with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module mdp_pwm
  import mdp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Valve coil drives
  output logic [7:0] pwm_o
);

  //----------------------------------------------------------------------------
  // Helper functions
  //----------------------------------------------------------------------------
  // Group channels all run from the group base timebase
  function automatic int tb_of(input int c);
    return (c < GROUP_BASE) ? c : GROUP_BASE;
  endfunction

  // Part of a period: p * v / sc, with v capped at sc
  function automatic logic [15:0] scale(input logic [15:0] p,
                                        input logic [15:0] v,
                                        input logic [15:0] sc);
    logic [15:0] vc;
    logic [31:0] prod;
    vc = (v > sc) ? sc : v;
    prod = 32'(p) * 32'(vc);
    return 16'(prod / 32'(sc));
  endfunction

  function automatic logic [15:0] sat16(input logic [31:0] q);
    return (|q[31:16]) ? 16'hFFFF : q[15:0];
  endfunction

  // Never shorter than the 5 kHz period of the chosen counter clock
  function automatic logic [15:0] clamp_period(input logic [15:0] p,
                                               input logic slow);
    logic [15:0] lim;
    lim = slow ? MIN_PERIOD_SLOW : MIN_PERIOD_FULL;
    return (p < lim) ? lim : p;
  endfunction

  // Compare value from duty, mode and dither phase
  function automatic logic [15:0] eff_cmp(input mdp_cfg_type cfg,
                                          input logic [15:0] duty,
                                          input logic up);
    logic [15:0] b;
    logic [15:0] a;
    logic [16:0] s;
    b = duty;
    a = cfg.dith_amp;
    s = 17'h00000;
    if (cfg.mode == percent_duty_mode)
      b = cfg.period - scale(cfg.period, {8'h00, duty[7:0]}, PERCENT_SCALE);
    else if (cfg.mode == permille_duty_mode)
      b = cfg.period - scale(cfg.period, duty, PERMILLE_SCALE);
    if (cfg.mode != raw_duty_mode)
      a = scale(cfg.period, cfg.dith_amp, PERCENT_SCALE);
    if (up)
      b = (b > a) ? b - a : 16'h0000;
    else
    begin
      s = {1'b0, b} + {1'b0, a};
      b = (s > {1'b0, cfg.period}) ? cfg.period : s[15:0];
    end
    return b;
  endfunction

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  logic acc_reg;
  logic acc_wr_reg;
  logic [7:0] acc_addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  logic [15:0] period_set_reg;
  logic [15:0] duty_set_reg;
  logic [15:0] amp_set_reg;
  logic [15:0] rate_set_reg;
  mdp_cmd_type cmd_reg;
  mdp_cfg_type cfg_reg [NUM_CH];
  logic [7:0] configured_reg;
  logic [15:0] duty_pend_reg [NUM_CH];
  logic [7:0] pend_reg;
  logic [15:0] duty_act_reg [NUM_CH];
  logic [15:0] dith_cnt_reg [NUM_CH];
  logic [7:0] dith_up_reg;
  logic [7:0] pwm_reg;
  logic [15:0] tb_cnt_reg [NUM_TB];
  logic [5:0] pre_cnt_reg [NUM_TB];
  mdp_state_type state_reg;
  logic [2:0] tgt_reg;
  logic [15:0] freq_reg;
  logic [31:0] rem_reg;
  logic [31:0] quo_reg;
  logic [31:0] den_reg;
  logic [5:0] step_reg;

  logic addr_acc;
  logic cmd_wr;
  mdp_cmd_type cmd_in;
  logic busy;
  logic div_done;
  logic [15:0] freq_cl;
  logic [4:0] tick;
  logic [4:0] wrap;
  logic [32:0] rem_sh;

  assign addr_acc = hsel_i & hready_i & htrans_i[1];
  assign cmd_in = mdp_cmd_type'(hwdata_i[7:0]);
  assign busy = (state_reg != st_idle);
  // Commands that arrive while a frequency is being derived are dropped
  assign cmd_wr = acc_reg & acc_wr_reg & (acc_addr_reg == ADDR_CMD) & ~busy;
  assign div_done = busy & (step_reg == 6'h00);
  assign freq_cl = (period_set_reg > MAX_PWM_HZ_W) ? MAX_PWM_HZ_W
                                                   : period_set_reg;
  assign rem_sh = {rem_reg, quo_reg[31]};

  //----------------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  //----------------------------------------------------------------------------
  // Address phase capture and registered read data
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      acc_reg <= 1'b0;
      acc_wr_reg <= 1'b0;
      acc_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b0;
      hresp_reg <= 1'b0;
    end
    else
    begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      acc_reg <= addr_acc;
      acc_wr_reg <= hwrite_i;
      acc_addr_reg <= haddr_i[7:0];
      if (addr_acc & ~hwrite_i)
      begin
        // Unmapped offsets read as zero
        hrdata_reg <= 32'h00000000;
        if (haddr_i[31:8] == 24'h000000)
        begin
          case (haddr_i[7:0])
            ADDR_PERIOD: hrdata_reg <= {16'h0000, period_set_reg};
            ADDR_DUTY: hrdata_reg <= {16'h0000, duty_set_reg};
            ADDR_DITH_AMP: hrdata_reg <= {16'h0000, amp_set_reg};
            ADDR_DITH_RATE: hrdata_reg <= {16'h0000, rate_set_reg};
            ADDR_CMD: hrdata_reg <= {24'h000000, cmd_reg};
            ADDR_STATUS:
              hrdata_reg <= {15'h0000, busy, pwm_reg, configured_reg};
            default: hrdata_reg <= 32'h00000000;
          endcase
        end
      end
      // High address bits make a write unmapped
      if (addr_acc & (haddr_i[31:8] != 24'h000000))
        acc_reg <= 1'b0;
    end
  end

  // Staging registers written in the data phase
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      period_set_reg <= 16'h0000;
      duty_set_reg <= 16'h0000;
      amp_set_reg <= 16'h0000;
      rate_set_reg <= 16'h0000;
      cmd_reg <= mdp_cmd_type'(8'h00);
    end
    else if (acc_reg & acc_wr_reg)
    begin
      case (acc_addr_reg)
        ADDR_PERIOD: period_set_reg <= hwdata_i[15:0];
        ADDR_DUTY: duty_set_reg <= hwdata_i[15:0];
        ADDR_DITH_AMP: amp_set_reg <= hwdata_i[15:0];
        ADDR_DITH_RATE: rate_set_reg <= hwdata_i[15:0];
        ADDR_CMD: if (!busy) cmd_reg <= cmd_in;
        default: ;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Frequency to period derivation: one shared serial divider
  //----------------------------------------------------------------------------
  // hertz turned into counts, then dither hertz into periods
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= st_idle;
      tgt_reg <= 3'h0;
      freq_reg <= 16'h0000;
      rem_reg <= 32'h00000000;
      quo_reg <= 32'h00000000;
      den_reg <= 32'h00000000;
      step_reg <= 6'h00;
    end
    else
    begin
      if (step_reg != 6'h00)
      begin
        step_reg <= step_reg - 6'h01;
        if (rem_sh >= {1'b0, den_reg})
        begin
          rem_reg <= 32'(rem_sh - {1'b0, den_reg});
          quo_reg <= {quo_reg[30:0], 1'b1};
        end
        else
        begin
          rem_reg <= rem_sh[31:0];
          quo_reg <= {quo_reg[30:0], 1'b0};
        end
      end
      case (state_reg)
        st_idle:
          if (cmd_wr & cmd_in.init & (cmd_in.mode != raw_duty_mode))
          begin
            state_reg <= st_period;
            tgt_reg <= cmd_in.chan;
            freq_reg <= freq_cl;
            rem_reg <= 32'h00000000;
            quo_reg <= cmd_in.slow_prescale_select ? BASE_SLOW_HZ
                                                   : BASE_FULL_HZ;
            den_reg <= 32'(freq_cl);
            step_reg <= DIV_STEPS;
          end
        st_period:
          if (div_done)
          begin
            // periods per dither half cycle = f / (2 * fd)
            state_reg <= st_dither;
            rem_reg <= 32'h00000000;
            quo_reg <= 32'(freq_reg);
            den_reg <= 32'({rate_set_reg, 1'b0});
            step_reg <= DIV_STEPS;
          end
        st_dither:
          if (div_done)
            state_reg <= st_idle;
        default: state_reg <= st_idle;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Channel configuration
  //----------------------------------------------------------------------------
  // configured bits only ever set; reset is the sole clear
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      configured_reg <= 8'h00;
      for (int c = 0; c < NUM_CH; c++)
        cfg_reg[c] <= '{raw_duty_mode, 1'b0, PERIOD_RST, 16'h0000, 16'h0000};
    end
    else
    begin
      // settings latched only on an init command
      if (cmd_wr & cmd_in.init)
      begin
        configured_reg[cmd_in.chan] <= 1'b1;
        cfg_reg[cmd_in.chan].slow_prescale_select <=
          cmd_in.slow_prescale_select;
        cfg_reg[cmd_in.chan].mode <= cmd_in.mode;
        // dither settings per channel at init
        cfg_reg[cmd_in.chan].dith_amp <= amp_set_reg;
        cfg_reg[cmd_in.chan].dith_rate <= rate_set_reg;
        // preload clamped to the 5 kHz least period
        if (cmd_in.mode == raw_duty_mode)
          cfg_reg[cmd_in.chan].period <=
            clamp_period(period_set_reg, cmd_in.slow_prescale_select);
      end
      if (div_done & (state_reg == st_period))
        cfg_reg[tgt_reg].period <= clamp_period(sat16(quo_reg),
          cfg_reg[tgt_reg].slow_prescale_select);
      if (div_done & (state_reg == st_dither))
        cfg_reg[tgt_reg].dith_rate <= sat16(quo_reg);
    end
  end

  //----------------------------------------------------------------------------
  // Timebases: four independent, one for the group
  //----------------------------------------------------------------------------
  // group channels share the group base timebase
  // independent channels run their own period
  always_comb
  begin
    for (int t = 0; t < NUM_TB; t++)
    begin
      tick[t] = ~cfg_reg[t].slow_prescale_select |
                (pre_cnt_reg[t] == PRESCALE_LAST);
      wrap[t] = tick[t] & (tb_cnt_reg[t] >= cfg_reg[t].period - 16'h0001);
    end
  end

  // divide by 64 prescaler when selected
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      for (int t = 0; t < NUM_TB; t++)
      begin
        tb_cnt_reg[t] <= 16'h0000;
        pre_cnt_reg[t] <= 6'h00;
      end
    else
      for (int t = 0; t < NUM_TB; t++)
      begin
        pre_cnt_reg[t] <= tick[t] ? 6'h00 : pre_cnt_reg[t] + 6'h01;
        if (wrap[t])
          tb_cnt_reg[t] <= 16'h0000;
        else if (tick[t])
          tb_cnt_reg[t] <= tb_cnt_reg[t] + 16'h0001;
      end
  end

  //----------------------------------------------------------------------------
  // Duty commit, dither and outputs
  //----------------------------------------------------------------------------
  // Duty staging: a new commit in a wrap cycle is kept pending
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pend_reg <= 8'h00;
      for (int c = 0; c < NUM_CH; c++)
      begin
        duty_pend_reg[c] <= 16'h0000;
        duty_act_reg[c] <= PERIOD_RST;
      end
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        // adopted only at the period boundary
        if (wrap[tb_of(c)] & pend_reg[c])
        begin
          duty_act_reg[c] <= duty_pend_reg[c];
          pend_reg[c] <= 1'b0;
        end
      end
      // A fresh init starts dark; FFFF would read as full on in percent mode
      if (cmd_wr & cmd_in.init)
        duty_act_reg[cmd_in.chan] <=
          (cmd_in.mode == raw_duty_mode) ? PERIOD_RST : 16'h0000;
      // duty taken only with commit set
      if (cmd_wr & cmd_in.commit)
      begin
        duty_pend_reg[cmd_in.chan] <= duty_set_reg;
        pend_reg[cmd_in.chan] <= 1'b1;
      end
    end
  end

  // phase flips every divider periods, a full swing in twice that
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      dith_up_reg <= 8'h00;
      for (int c = 0; c < NUM_CH; c++)
        dith_cnt_reg[c] <= 16'h0000;
    end
    else
      for (int c = 0; c < NUM_CH; c++)
        if (wrap[tb_of(c)])
        begin
          // A divider of zero behaves as one
          if (dith_cnt_reg[c] + 16'h0001 >= cfg_reg[c].dith_rate)
          begin
            dith_cnt_reg[c] <= 16'h0000;
            dith_up_reg[c] <= ~dith_up_reg[c];
          end
          else
            dith_cnt_reg[c] <= dith_cnt_reg[c] + 16'h0001;
        end
  end

  // high from compare match until the wrap
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      pwm_reg <= 8'h00;
    else
      for (int c = 0; c < NUM_CH; c++)
        pwm_reg[c] <= configured_reg[c] & (tb_cnt_reg[tb_of(c)] >=
          eff_cmp(cfg_reg[c], duty_act_reg[c], dith_up_reg[c]));
  end

  // Outputs straight from flip-flops
  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = hreadyout_reg;
  assign hresp_o = hresp_reg;
  assign pwm_o = pwm_reg;

endmodule // mdp_pwm
`default_nettype wire

// ===== mdp_pwm_chk.sv
// Port-level assertions for the dithered multichannel PWM block
`timescale 1ns/1ps
`default_nettype none
module mdp_pwm_chk
  import mdp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bus side
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Coil drives
  input wire logic [7:0] pwm_o
);
  //----------------------------------------------------------------------------
  // Helper logic
  //----------------------------------------------------------------------------
  logic cmd_seen_reg;
  logic [15:0] gap1_reg;
  logic [15:0] gap4_reg;

  // Remembers that a command was ever taken; outputs may only move after one
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      cmd_seen_reg <= 1'b0;
    else if (hsel_i && hready_i && htrans_i[1] && hwrite_i &&
             haddr_i == {24'h0, ADDR_CMD})
      cmd_seen_reg <= 1'b1;
  end

  // Cycles since the last wrap of channel 1, whose preload sits below the
  // least period; a fall only happens at a wrap, so this is the clamp edge
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      gap1_reg <= 16'h0;
    else if ($fell(pwm_o[1]))
      gap1_reg <= 16'h1;
    else if (gap1_reg != 16'h0 && gap1_reg != 16'hFFFF)
      gap1_reg <= gap1_reg + 16'h1;
  end

  // Same for the group timebase, which runs slow in the bench
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      gap4_reg <= 16'h0;
    else if ($fell(pwm_o[4]))
      gap4_reg <= 16'h1;
    else if (gap4_reg != 16'h0 && gap4_reg != 16'hFFFF)
      gap4_reg <= gap4_reg + 16'h1;
  end

  //----------------------------------------------------------------------------
  // Properties
  //----------------------------------------------------------------------------
  sequence s_read_taken;
    hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  endsequence

  sequence s_unmapped;
    haddr_i[31:8] != 24'h0;
  endsequence

  // Reset itself is the cause here, so no disable condition
  a_reset_quiet: assert property (@(posedge clk_i)
    !nrst_i |=> pwm_o == 8'h00 && !hreadyout_o && hrdata_o == 32'h0)
    else $error("outputs not quiet after reset");
  a_ready_stays: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $past(nrst_i) |-> hreadyout_o)
    else $error("wait state inserted");
  a_resp_okay: assert property (@(posedge clk_i) disable iff (!nrst_i)
    hresp_o == 1'b0)
    else $error("error response given");
  a_unmapped_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_read_taken ##0 s_unmapped |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(hsel_i && hready_i && htrans_i[1] && !hwrite_i) |=> $stable(hrdata_o))
    else $error("read data moved without a read");
  a_idle_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !cmd_seen_reg |-> pwm_o == 8'h00)
    else $error("output active before any command");
  a_rate_limit1: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(pwm_o[1]) && gap1_reg != 16'h0 |-> gap1_reg >= 16'h2710)
    else $error("channel 1 faster than limit");
  a_rate_limit4: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(pwm_o[4]) && gap4_reg != 16'h0 |-> gap4_reg >= 16'h2710)
    else $error("group faster than limit");
endmodule // mdp_pwm_chk
`default_nettype wire

// ===== mdp_coil_model.sv
// Valve coil load model that times the high and period of each drive
`timescale 1ns/1ps
`default_nettype none
module mdp_coil_model (
  // Clock
  input wire logic clk_i,
  // Coil drives
  input wire logic [7:0] pwm_i,
  // Measured times in clock cycles
  output logic [7:0][15:0] on_len_o,
  output logic [7:0][15:0] prev_len_o,
  output logic [7:0][15:0] per_len_o
);
  logic [31:0] cyc = 32'h0;
  logic [7:0] last = 8'h00;
  logic [7:0][31:0] rise_t = '0;

  initial
  begin
    on_len_o = '0;
    prev_len_o = '0;
    per_len_o = '0;
  end

  // A coil only sees edges; period is rise to rise, on time rise to fall
  always @(posedge clk_i)
  begin
    cyc <= cyc + 32'h1;
    last <= pwm_i;
    for (int n = 0; n < 8; n++)
    begin
      if (pwm_i[n] && !last[n])
      begin
        per_len_o[n] <= 16'(cyc - rise_t[n]);
        rise_t[n] <= cyc;
      end
      if (!pwm_i[n] && last[n])
      begin
        prev_len_o[n] <= on_len_o[n];
        on_len_o[n] <= 16'(cyc - rise_t[n]);
      end
    end
  end
endmodule // mdp_coil_model
`default_nettype wire

// ===== tb.sv
// Self-checking testbench for the dithered multichannel PWM block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mdp_pkg::*;
  //----------------------------------------------------------------------------
  // Signals
  //----------------------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] pwm;
  logic [7:0][15:0] on_len, prev_len, per_len;
  int mismatches = 0;
  int check_count = 0;

  // 50 MHz
  always #10 clk = ~clk;

  mdp_pwm i_mdp_pwm (.clk_i(clk), .nrst_i(nrst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .pwm_o(pwm));
  mdp_coil_model i_mdp_coil_model (.clk_i(clk), .pwm_i(pwm),
    .on_len_o(on_len), .prev_len_o(prev_len), .per_len_o(per_len));

  //----------------------------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------------------------
  task finish_test;
    $display("mismatches %0d check_count %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s %h not %h", $time, m, seen, exp);
    end
  endtask

  // Bounded wait for hready; a hang ends the run
  task wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      mismatches++;
      finish_test;
    end
  endtask

  // One single AHB transfer; read data lands in rd at the data-phase edge
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask

  task cmd(input logic [2:0] ch, input logic ini, input logic cm,
           input mdp_mode_type m, input logic slow);
    mdp_cmd_type c;
    int n;
    c = '{slow_prescale_select: slow, mode: m, commit: cm, init: ini, chan: ch};
    ahb(1'b1, {24'h0, ADDR_CMD}, {24'h0, c});
    // Frequency modes divide for a while; poll busy before the next command
    n = 0;
    do
    begin
      ahb(1'b0, {24'h0, ADDR_STATUS}, 32'h0);
      n++;
    end while (rd[16] !== 1'b0 && n < 200);
    chk({31'h0, rd[16]}, 32'h0, "busy stuck");
    if (rd[16] !== 1'b0)
      finish_test;
  endtask

  task cfg(input logic [2:0] ch, input mdp_mode_type m, input logic slow,
           input logic [15:0] per, duty, amp, rate);
    ahb(1'b1, {24'h0, ADDR_PERIOD}, {16'h0, per});
    ahb(1'b1, {24'h0, ADDR_DUTY}, {16'h0, duty});
    ahb(1'b1, {24'h0, ADDR_DITH_AMP}, {16'h0, amp});
    ahb(1'b1, {24'h0, ADDR_DITH_RATE}, {16'h0, rate});
    cmd(ch, 1'b1, 1'b1, m, slow);
  endtask

  task chl(input int ch, input logic [15:0] on, input logic [15:0] per);
    chk({16'h0, on_len[ch]}, {16'h0, on}, "on time");
    chk({16'h0, per_len[ch]}, {16'h0, per}, "period");
  endtask

  //----------------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------------
  task t_reset;
    chk({24'h0, pwm}, 32'h0, "pwm at reset");
    ahb(1'b0, {24'h0, ADDR_STATUS}, 32'h0);
    chk(rd, 32'h0, "status at reset");
    ahb(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_0100, 32'h0);
    chk(rd, 32'h0, "unmapped read");
  endtask

  // Software gives group channels 4 and 5 one period and one mode
  task t_setup;
    cfg(3'h0, raw_duty_mode, 1'b0, 16'h2EE0, 16'h2328, 16'h0, 16'h0);
    cfg(3'h1, raw_duty_mode, 1'b0, 16'h0064, 16'h1388, 16'h03E8, 16'h0001);
    cfg(3'h2, percent_duty_mode, 1'b0, 16'h1388, 16'h0019, 16'h0, 16'h0);
    cfg(3'h3, permille_duty_mode, 1'b0, 16'h0FA0, 16'h012C, 16'h0, 16'h0);
    cfg(3'h4, raw_duty_mode, 1'b1, 16'h00C8, 16'h0064, 16'h0, 16'h0);
    cfg(3'h5, raw_duty_mode, 1'b1, 16'h00C8, 16'h0096, 16'h0, 16'h0);
  endtask

  task t_waves;
    logic ok;
    repeat (34000) @(posedge clk);
    chl(0, 16'h0BB8, 16'h2EE0);
    chl(2, 16'h09C4, 16'h2710);
    chl(3, 16'h0EA6, 16'h30D4);
    chl(4, 16'h1900, 16'h3200);
    chl(5, 16'h0C80, 16'h3200);
    ok = (on_len[1] == 16'h1770 && prev_len[1] == 16'h0FA0) ||
         (on_len[1] == 16'h0FA0 && prev_len[1] == 16'h1770);
    chk({31'h0, ok}, 32'h1, "dither swing");
  endtask

  task t_no_commit;
    // A duty that would visibly change the pulse if it were wrongly adopted
    ahb(1'b1, {24'h0, ADDR_DUTY}, 32'h0000_0FA0);
    cmd(3'h0, 1'b0, 1'b0, raw_duty_mode, 1'b0);
    repeat (13000) @(posedge clk);
    chl(0, 16'h0BB8, 16'h2EE0);
    ahb(1'b0, {24'h0, ADDR_STATUS}, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h3F, "configured set");
  endtask

  task t_commit;
    logic ok;
    ahb(1'b1, {24'h0, ADDR_DUTY}, 32'h0000_1770);
    cmd(3'h0, 1'b0, 1'b1, raw_duty_mode, 1'b0);
    repeat (26000) @(posedge clk);
    chl(0, 16'h1770, 16'h2EE0);
    // Either the old or the new pulse, never a cut one
    ok = prev_len[0] == 16'h0BB8 || prev_len[0] == 16'h1770;
    chk({31'h0, ok}, 32'h1, "pulse cut at commit");
  endtask

  //----------------------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_setup;
    t_waves;
    t_no_commit;
    t_commit;
    finish_test;
  end
endmodule // tb

bind mdp_pwm mdp_pwm_chk i_mdp_pwm_chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .pwm_o(pwm_o));
`default_nettype wire
